/* bench/fb_master_model.sv */
// Fieldbus master model: finds the slave, commands states, streams frames.
// Assumes its tasks are called just after a rising edge of core_clk.
`timescale 1ns/100ps
`default_nettype none

module fb_master_model #(
	parameter int PERIOD = 6 // Frame spacing, kept far below any watchdog
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic link_ok,
	input wire logic pd_en,
	input wire logic pd_val,
	output logic al_req_valid,
	output logic [3:0] al_req_state,
	output logic pd_rx_strobe,
	output logic pd_nonzero,
	output logic fb_fault_reset,
	output logic wc_state
);
	int cnt; // Position within the frame period
	logic ident_done; // Slave identified

	// Idle request lines at start
	initial
	begin
		al_req_valid = 1'b0;
		al_req_state = 4'h0;
		fb_fault_reset = 1'b0;
	end

	// Cyclic frames; only the strobe is withheld while the link is lost, the count runs on
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 0;
			pd_rx_strobe <= 1'b0;
			pd_nonzero <= 1'b0;
			wc_state <= 1'b0;
			ident_done <= 1'b0;
		end
		else
		begin
			ident_done <= 1'b1;
			cnt <= (cnt >= PERIOD - 1) ? 0 : cnt + 1;
			pd_rx_strobe <= pd_en && link_ok && cnt == 0;
			// Qualifier is meaningless between frames, so it toggles
			pd_nonzero <= (pd_en && link_ok && cnt == 0) ? pd_val : ~pd_nonzero;
			wc_state <= pd_en && !link_ok;
		end
	end

	// One state request, only after identification
	task automatic command(input logic [3:0] s);
		wait (ident_done);
		al_req_valid <= 1'b1;
		al_req_state <= s;
		@(posedge core_clk);
		al_req_valid <= 1'b0;
		al_req_state <= ~s;
	endtask : command

	// One fault reset pulse
	task automatic reset_fault();
		fb_fault_reset <= 1'b1;
		@(posedge core_clk);
		fb_fault_reset <= 1'b0;
	endtask : reset_fault
endmodule : fb_master_model
`default_nettype wire

/* bench/fieldbus_fault_supervisor_asserts.sv */
// Checker for the fieldbus fault supervisor, watching its top module ports.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "fbsup_cfg.svh"

module fieldbus_fault_supervisor_asserts (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic al_req_valid,
	input wire logic [3:0] al_req_state,
	input wire logic pd_config_valid,
	input wire logic link_in_up,
	input wire logic fieldbus_timeout_fault,
	input wire logic [4:0] fault_cause_detail_code,
	input wire logic [3:0] al_state_code,
	input wire logic control_from_process_data,
	input wire logic control_from_mailbox
);
	// ----
	// Properties, all on core_clk
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_resp_always_okay: assert property (hresp == 1'b0)
		else $error("slave response not okay");
	a_wait_on_ce: assert property (!ce |=> !hreadyout)
		else $error("ready high after a disabled cycle");
	a_state_one_hot: assert property ($onehot(al_state_code))
		else $error("state code not one hot");
	a_state_by_request: assert property ($changed(al_state_code) |->
		$past(al_req_valid, 2) && al_state_code == $past(al_req_state, 2))
		else $error("state changed without a request");
	a_op_gated: assert property ((al_state_code == `FBS_AL_OP && $past(al_state_code) != `FBS_AL_OP) |->
		$past(pd_config_valid, 2) && $past(al_state_code) == `FBS_AL_SAFEOP)
		else $error("operational entered illegally");
	a_safeop_gated: assert property ((al_state_code == `FBS_AL_SAFEOP && $past(al_state_code) != `FBS_AL_SAFEOP) |->
		$past(pd_config_valid, 2) && $past(al_state_code) != `FBS_AL_INIT)
		else $error("safe operational entered illegally");
	a_mailbox_in_preop: assert property (al_state_code == `FBS_AL_PREOP |->
		control_from_mailbox && !control_from_process_data)
		else $error("wrong control path in pre operational");
	a_pd_needs_op: assert property (control_from_process_data |->
		al_state_code == `FBS_AL_OP && !control_from_mailbox)
		else $error("process data control outside operational");
	a_detail_legal: assert property (fieldbus_timeout_fault |->
		fault_cause_detail_code inside {`FBS_DETAIL_LINK, `FBS_DETAIL_WD, `FBS_DETAIL_ILLEGAL})
		else $error("fault with unknown detail code");
	a_reset_needs_link: assert property ($fell(fieldbus_timeout_fault) |-> $past(link_in_up, 3))
		else $error("fault cleared while link down");
endmodule : fieldbus_fault_supervisor_asserts

bind fieldbus_fault_supervisor fieldbus_fault_supervisor_asserts u_fieldbus_fault_supervisor_asserts (.*);
`default_nettype wire

/* bench/testbench.sv */
// Testbench for the fieldbus fault supervisor: registers, states and faults.
// Assumes the master model drives the protocol side and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`include "fbsup_cfg.svh"

module testbench;
	logic core_clk, arst_n, ce, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, seed, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic al_req_valid, pd_config_valid, pd_rx_strobe, pd_nonzero, fb_fault_reset;
	logic [3:0] al_req_state, al_state_code;
	logic link_in_up, link_out_up, motor_running, reset_button, io_fault_reset;
	logic fieldbus_timeout_fault, control_from_process_data, control_from_mailbox;
	logic [4:0] fault_cause_detail_code;
	logic pd_en, pd_val; // Frame stream on, frame content nonzero
	int n_errors = 0;
	int cmp_count = 0;
	int wd_t;

	// Short tick keeps every timer run brief
	fieldbus_fault_supervisor #(.TICK_CYCLES(2)) u_fieldbus_fault_supervisor (.*, .hready(hreadyout));
	fb_master_model u_fb_master_model (.core_clk, .arst_n, .link_ok(link_in_up), .pd_en, .pd_val,
		.al_req_valid, .al_req_state, .pd_rx_strobe, .pd_nonzero, .fb_fault_reset, .wc_state());

	// ----
	// Helpers
	// ----
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Low status fields: detail, fault, state
	function automatic logic [31:0] st_exp(input logic [3:0] s, input logic f, input logic [4:0] d);
		st_exp = {22'h0, d, f, s};
	endfunction : st_exp

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Single transfer; waits on ready in each phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb(1'b0, a, 32'h0000_0000);
		chk(rd & m, e);
	endtask : rchk

	// State code shows two edges after the request is taken
	task automatic req(input logic [3:0] s, input logic [3:0] e);
		u_fb_master_model.command(s);
		cyc(2);
		chk(32'(al_state_code), 32'(e));
	endtask : req

	task automatic wflt(input logic e, input logic [4:0] d, input int n);
		repeat (n) if (fieldbus_timeout_fault !== e) @(posedge core_clk);
		chk({26'h0, fieldbus_timeout_fault, fault_cause_detail_code}, {26'h0, e, d});
	endtask : wflt

	// Set the input-port link, wait, expect no fault
	task automatic quiet(input logic l, input int n);
		link_in_up <= l;
		cyc(n);
		chk(32'(fieldbus_timeout_fault), 32'h0000_0000);
	endtask : quiet

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// Hang guard, far beyond the sequence length
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		stop_test();
	end

	// ----
	// Main sequence
	// ----
	initial
	begin
		{hsel, hwrite, htrans, haddr, hwdata, pd_config_valid, motor_running} = '0;
		{reset_button, io_fault_reset, pd_en, pd_val} = '0;
		{link_in_up, link_out_up, ce} = 3'h7;
		hsize = 3'b010;
		seed = 32'h0001_0EB0;
		arst_n = 1'b0;
		cyc(16);
		arst_n <= 1'b1;
		cyc(1);
		rchk(`FBS_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rchk(`FBS_OFS_COMM_TIMEOUT, 32'hFFFF_FFFF, 32'h0000_0000);
		rchk(`FBS_OFS_STATUS, 32'h0000_03FF, st_exp(`FBS_AL_INIT, 1'b0, 5'h00));
		ahb(1'b1, 8'h14, 32'hFFFF_FFFF);
		rchk(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
		ce <= 1'b0;
		cyc(3);
		ce <= 1'b1;
		cyc(20);
		// Protocol gating and control path
		req(`FBS_AL_SAFEOP, `FBS_AL_INIT);
		req(`FBS_AL_PREOP, `FBS_AL_PREOP);
		chk(32'(control_from_mailbox), 32'h0000_0001);
		req(`FBS_AL_SAFEOP, `FBS_AL_PREOP);
		rchk(`FBS_OFS_STATUS, 32'h0000_800F, 32'h0000_8002);
		req(`FBS_AL_OP, `FBS_AL_PREOP);
		pd_config_valid <= 1'b1;
		pd_en <= 1'b1;
		req(`FBS_AL_SAFEOP, `FBS_AL_SAFEOP);
		req(`FBS_AL_OP, `FBS_AL_OP);
		chk(32'({control_from_process_data, control_from_mailbox}), 32'h0000_0002);
		// Random watchdog time, well above the frame period
		seed = lfsr(seed);
		wd_t = 8 + int'(seed[3:0]);
		ahb(1'b1, `FBS_OFS_WD_TIME, 32'(wd_t));
		ahb(1'b1, `FBS_OFS_COMM_TIMEOUT, 32'h0000_0004);
		ahb(1'b1, `FBS_OFS_CTRL, 32'h0000_0003);
		rchk(`FBS_OFS_WD_TIME, 32'h0000_FFFF, 32'(wd_t));
		// Not armed before nonzero frames: link loss is harmless
		quiet(1'b0, 60);
		pd_val <= 1'b1;
		quiet(1'b1, 20);
		link_in_up <= 1'b0;
		wflt(1'b1, `FBS_DETAIL_LINK, 100);
		rchk(`FBS_OFS_STATUS, 32'h0000_03FF, st_exp(`FBS_AL_OP, 1'b1, `FBS_DETAIL_LINK));
		reset_button <= 1'b1;
		cyc(4);
		reset_button <= 1'b0;
		wflt(1'b1, `FBS_DETAIL_LINK, 4);
		link_in_up <= 1'b1;
		cyc(20);
		io_fault_reset <= 1'b1;
		cyc(4);
		io_fault_reset <= 1'b0;
		wflt(1'b0, `FBS_DETAIL_LINK, 20);
		// A short link blip is absorbed by the activation delay
		ahb(1'b1, `FBS_OFS_CTRL, 32'h0000_0005);
		seed = lfsr(seed);
		quiet(1'b0, 1 + int'(seed[1:0]));
		quiet(1'b1, 30);
		// Frames stop: watchdog cause
		pd_en <= 1'b0;
		wflt(1'b1, `FBS_DETAIL_WD, 300);
		u_fb_master_model.reset_fault();
		wflt(1'b1, `FBS_DETAIL_WD, 4);
		pd_en <= 1'b1;
		cyc(20);
		u_fb_master_model.reset_fault();
		wflt(1'b0, `FBS_DETAIL_WD, 20);
		// State change while running
		motor_running <= 1'b1;
		cyc(4);
		req(`FBS_AL_PREOP, `FBS_AL_PREOP);
		wflt(1'b1, `FBS_DETAIL_ILLEGAL, 60);
		ahb(1'b1, `FBS_OFS_FAULT_RESET, 32'h0000_0001);
		wflt(1'b1, `FBS_DETAIL_ILLEGAL, 4);
		motor_running <= 1'b0;
		cyc(4);
		req(`FBS_AL_SAFEOP, `FBS_AL_SAFEOP);
		req(`FBS_AL_OP, `FBS_AL_OP);
		cyc(4);
		ahb(1'b1, `FBS_OFS_FAULT_RESET, 32'h0000_0001);
		wflt(1'b0, `FBS_DETAIL_ILLEGAL, 20);
		// Other control place; out port only loses frame control
		ahb(1'b1, `FBS_OFS_CTRL, 32'h0000_0004);
		quiet(1'b0, 60);
		chk(32'({control_from_process_data, control_from_mailbox}), 32'h0000_0001);
		quiet(1'b1, 30);
		// No watchdog and zero timeout: never faults
		ahb(1'b1, `FBS_OFS_COMM_TIMEOUT, 32'h0000_0000);
		ahb(1'b1, `FBS_OFS_CTRL, 32'h0000_0001);
		quiet(1'b0, 60);
		quiet(1'b1, 30);
		// Zero watchdog time never expires
		ahb(1'b1, `FBS_OFS_WD_TIME, 32'h0000_0000);
		ahb(1'b1, `FBS_OFS_COMM_TIMEOUT, 32'h0000_0004);
		ahb(1'b1, `FBS_OFS_CTRL, 32'h0000_0005);
		pd_en <= 1'b0;
		quiet(1'b1, 100);
		stop_test();
	end
endmodule : testbench
`default_nettype wire

/* rtl/fbs_delay_timer.sv */
// Delay timer: counts ticks while run is high and flags expiry at a limit.
// Assumes tick is a one-cycle pulse from a shared prescaler.
`timescale 1ns/100ps
`default_nettype none

module fbs_delay_timer #(
	parameter int W = 16
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic run,
	input wire logic tick,
	input wire logic [W-1:0] limit,
	output logic expired
);

	// Elapsed ticks since run went high
	logic [W-1:0] count_r;

	// ----------------------------------------------------------------
	// Count while running; dropping run restarts from zero
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count_r <= '0;
			expired <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				// Condition gone before expiry: nothing is raised
				count_r <= '0;
				expired <= 1'b0;
			end
			else if (count_r >= limit)
			begin
				expired <= 1'b1;
			end
			else if (tick)
			begin
				// Saturates at the limit, so no wrap
				count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule : fbs_delay_timer

`default_nettype wire

/* rtl/fbs_sync2.sv */
// Two flip-flop synchroniser for a group of level inputs.
// Assumes each bit is an independent slow level from a pin.
`timescale 1ns/100ps
`default_nettype none

module fbs_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// First stage, read only by the second stage
	logic [WIDTH-1:0] meta_r;

	// ----------------------------------------------------------------
	// Two stages per bit
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else if (ce)
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : fbs_sync2

`default_nettype wire

/* rtl/fbsup_cfg.svh */
// Constants for the fieldbus fault supervisor: register map, field positions,
// reset values, cause detail codes and timing.
// Assumes a 200 MHz core clock and a 32-bit AHB-Lite register port.
`ifndef FBSUP_CFG_SVH
`define FBSUP_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FBS_OFS_CTRL 8'h00
`define FBS_OFS_WD_TIME 8'h04
`define FBS_OFS_COMM_TIMEOUT 8'h08
`define FBS_OFS_FAULT_RESET 8'h0C
`define FBS_OFS_STATUS 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FBS_CTRL_PLACE_FB 0
`define FBS_CTRL_ARM_NONZERO 1
`define FBS_CTRL_WD_CFG 2
`define FBS_RST_REQ 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FBS_CTRL_RESET 3'h0
`define FBS_WD_TIME_RESET 16'h0000
`define FBS_COMM_TIMEOUT_RESET 16'h0000

// ----------------------------------------------------------------
// Cause detail codes and protocol state codes
// ----------------------------------------------------------------
`define FBS_DETAIL_NONE 5'h00
`define FBS_DETAIL_LINK 5'h05
`define FBS_DETAIL_WD 5'h01
`define FBS_DETAIL_ILLEGAL 5'h12
`define FBS_AL_INIT 4'h1
`define FBS_AL_PREOP 4'h2
`define FBS_AL_SAFEOP 4'h4
`define FBS_AL_OP 4'h8

// ----------------------------------------------------------------
// Timing: one timer tick is one microsecond
// ----------------------------------------------------------------
`define FBS_CLK_PERIOD_NS 5
`define FBS_TICK_NS 1000
`define FBS_TICK_CYCLES (`FBS_TICK_NS / `FBS_CLK_PERIOD_NS)

`endif

/* rtl/fbsup_pkg.sv */
// Types shared by the fieldbus fault supervisor files.
// Assumes nothing of its surroundings.
package fbsup_pkg;

	// Protocol state of the slave
	typedef enum logic [1:0] {
		AL_INIT,
		AL_PREOP,
		AL_SAFEOP,
		AL_OP
	} al_state_e;

endpackage : fbsup_pkg

/* rtl/fieldbus_fault_supervisor.sv */
// Fieldbus fault supervisor: protocol state gating, control authority,
// fault trigger causes, activation delay, latching and reset.
// Assumes protocol requests and process data strobes arrive on core_clk;
// link, motor-run and reset button/terminal inputs are asynchronous pins.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fbsup_cfg.svh"

// Operation
// - Stay Init until master commands Pre-Operational
// - Refuse Operational path without valid configuration
// - Mailbox control in PreOp, process data in Op
// - Raise fault only under fieldbus control place
// - Link loss on input port triggers
// - Missing process data past watchdog triggers
// - State change while motor runs triggers
// - Record detail code 5, 1 or 18
// - Ignore reset while any cause present
// - Link cause clears when link returns
// - Watchdog cause clears back in Operational
// - Illegal-change cause clears at original state
// - Counters delay activation; early clear cancels
// - No watchdog and zero timeout: never fault
// - Zero watchdog time never expires
// - Optionally arm after nonzero process data
// - Output-port entry disables process data control
// - Reset from button, terminal or fieldbus
module fieldbus_fault_supervisor #(
	parameter int TICK_CYCLES = `FBS_TICK_CYCLES,
	parameter int TIME_W = 16
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Protocol side, same clock
	input wire logic al_req_valid,
	input wire logic [3:0] al_req_state,
	input wire logic pd_config_valid,
	input wire logic pd_rx_strobe,
	input wire logic pd_nonzero,
	input wire logic fb_fault_reset,
	// Pins
	input wire logic link_in_up,
	input wire logic link_out_up,
	input wire logic motor_running,
	input wire logic reset_button,
	input wire logic io_fault_reset,
	// Results
	output logic fieldbus_timeout_fault,
	output logic [4:0] fault_cause_detail_code,
	output logic [3:0] al_state_code,
	output logic control_from_process_data,
	output logic control_from_mailbox
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// State to wire code, used for status and output
	function automatic logic [3:0] al_code(input fbsup_pkg::al_state_e s);
		logic [3:0] c;
		c = `FBS_AL_INIT;
		unique case (s)
			fbsup_pkg::AL_INIT: c = `FBS_AL_INIT;
			fbsup_pkg::AL_PREOP: c = `FBS_AL_PREOP;
			fbsup_pkg::AL_SAFEOP: c = `FBS_AL_SAFEOP;
			fbsup_pkg::AL_OP: c = `FBS_AL_OP;
		endcase
		return c;
	endfunction : al_code

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic link_in_s; // Link on input port
	logic link_out_s; // Link on output port
	logic motor_run_s; // Drive reports motor running
	logic button_s; // Local reset button
	logic io_reset_s; // Terminal reset input

	fbs_sync2 #(.WIDTH(5)) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.ce(ce),
		.async_in({link_in_up, link_out_up, motor_running, reset_button, io_fault_reset}),
		.sync_out({link_in_s, link_out_s, motor_run_s, button_s, io_reset_s})
	);

	// ----------------------------------------------------------------
	// Register file and AHB-Lite slave
	// ----------------------------------------------------------------
	logic place_fb_r; // Control place is the fieldbus
	logic arm_nonzero_r; // Arm only after nonzero process data
	logic wd_cfg_r; // Sync manager watchdog configured
	logic [TIME_W-1:0] wd_time_r; // Watchdog time in ticks
	logic [TIME_W-1:0] comm_to_r; // Communication timeout in ticks
	logic sw_reset_r; // Software fault reset pulse
	logic wr_pend_r; // Write data phase pending
	logic [7:0] wr_addr_r; // Latched write offset
	logic [31:0] status_w; // Status word
	logic addr_ok; // Valid address phase

	assign addr_ok = hsel && hready && htrans[1];

	// Address phase capture; zero wait states while ce stays high, always OKAY
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else if (ce)
		begin
			wr_pend_r <= addr_ok && hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	// Ready tracks clock enable so a frozen block stalls the bus
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= ce;
			hresp <= 1'b0;
		end
	end

	// Writes land in the data phase
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{wd_cfg_r, arm_nonzero_r, place_fb_r} <= `FBS_CTRL_RESET;
			wd_time_r <= `FBS_WD_TIME_RESET;
			comm_to_r <= `FBS_COMM_TIMEOUT_RESET;
			sw_reset_r <= 1'b0;
		end
		else if (ce)
		begin
			sw_reset_r <= 1'b0;
			if (wr_pend_r)
			begin
				unique case (wr_addr_r)
					`FBS_OFS_CTRL:
					begin
						place_fb_r <= hwdata[`FBS_CTRL_PLACE_FB];
						arm_nonzero_r <= hwdata[`FBS_CTRL_ARM_NONZERO];
						wd_cfg_r <= hwdata[`FBS_CTRL_WD_CFG];
					end
					`FBS_OFS_WD_TIME: wd_time_r <= hwdata[TIME_W-1:0];
					`FBS_OFS_COMM_TIMEOUT: comm_to_r <= hwdata[TIME_W-1:0];
					`FBS_OFS_FAULT_RESET: sw_reset_r <= hwdata[`FBS_RST_REQ];
					default: ; // Unmapped or read-only: ignored
				endcase
			end
		end
	end

	// Read data loaded at the address phase, held in the data phase
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			hrdata <= 32'h0000_0000;
		else if (ce && addr_ok && !hwrite)
		begin
			unique case (haddr[7:0])
				`FBS_OFS_CTRL: hrdata <= {29'h0000_0000, wd_cfg_r, arm_nonzero_r, place_fb_r};
				`FBS_OFS_WD_TIME: hrdata <= 32'(wd_time_r);
				`FBS_OFS_COMM_TIMEOUT: hrdata <= 32'(comm_to_r);
				`FBS_OFS_STATUS: hrdata <= status_w;
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Protocol state machine
	// ----------------------------------------------------------------
	fbsup_pkg::al_state_e al_r; // Current protocol state
	logic refused_r; // Last request was refused

	// Only commanded transitions; power-up holds Init
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			al_r <= fbsup_pkg::AL_INIT;
			refused_r <= 1'b0;
		end
		else if (ce && al_req_valid)
		begin
			refused_r <= 1'b0;
			unique case (al_req_state)
				`FBS_AL_INIT: al_r <= fbsup_pkg::AL_INIT;
				`FBS_AL_PREOP: al_r <= fbsup_pkg::AL_PREOP;
				`FBS_AL_SAFEOP:
				begin
					// Upward only from PreOp, and only configured
					if (pd_config_valid && al_r != fbsup_pkg::AL_INIT)
						al_r <= fbsup_pkg::AL_SAFEOP;
					else
						refused_r <= 1'b1;
				end
				`FBS_AL_OP:
				begin
					if (pd_config_valid && (al_r == fbsup_pkg::AL_SAFEOP || al_r == fbsup_pkg::AL_OP))
						al_r <= fbsup_pkg::AL_OP;
					else
						refused_r <= 1'b1;
				end
				default: refused_r <= 1'b1; // Unknown state code
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control authority
	// ----------------------------------------------------------------
	// Output-port entry reaches Op but cannot steer the motor
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			control_from_process_data <= 1'b0;
			control_from_mailbox <= 1'b0;
			al_state_code <= `FBS_AL_INIT;
		end
		else if (ce)
		begin
			control_from_process_data <= (al_r == fbsup_pkg::AL_OP) && link_in_s;
			control_from_mailbox <= (al_r == fbsup_pkg::AL_PREOP) ||
				((al_r == fbsup_pkg::AL_OP) && !link_in_s && link_out_s);
			al_state_code <= al_code(al_r);
		end
	end

	// ----------------------------------------------------------------
	// Tick prescaler and timers
	// ----------------------------------------------------------------
	logic [15:0] presc_r; // Cycle count within one tick
	logic tick_r; // One-cycle tick
	logic wd_run; // Watchdog armed and waiting
	logic wd_expired; // Watchdog ran out
	logic comm_run; // Some cause present and faulting enabled
	logic comm_expired; // Activation delay elapsed
	logic fault_possible; // Any activation path configured

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			presc_r <= 16'h0000;
			tick_r <= 1'b0;
		end
		else if (ce)
		begin
			tick_r <= (presc_r == 16'(TICK_CYCLES - 1));
			presc_r <= (presc_r == 16'(TICK_CYCLES - 1)) ? 16'h0000 : presc_r + 16'h0001;
		end
	end

	// Each received frame restarts the watchdog; zero time disables it
	assign wd_run = wd_cfg_r && (wd_time_r != '0) && (al_r == fbsup_pkg::AL_OP) && !pd_rx_strobe;

	fbs_delay_timer #(.W(TIME_W)) u_wd_timer (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.ce(ce),
		.run(wd_run),
		.tick(tick_r),
		.limit(wd_time_r),
		.expired(wd_expired)
	);

	logic link_cause; // Link down on input port
	logic wd_cause_r; // Watchdog cause held
	logic ill_cause_r; // Illegal state change cause held
	logic cause_any; // Any cause present
	fbsup_pkg::al_state_e hold_state_r; // State held while motor ran

	assign link_cause = !link_in_s;
	assign cause_any = link_cause || wd_cause_r || ill_cause_r;
	assign fault_possible = wd_cfg_r || (comm_to_r != '0);
	assign comm_run = cause_any && fault_possible;

	// Delay before activation; a cause that clears first restarts it
	fbs_delay_timer #(.W(TIME_W)) u_comm_timer (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.ce(ce),
		.run(comm_run),
		.tick(tick_r),
		.limit(comm_to_r),
		.expired(comm_expired)
	);

	// ----------------------------------------------------------------
	// Cause tracking; a new set wins over a same-cycle clear
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			wd_cause_r <= 1'b0;
		else if (ce)
		begin
			if (wd_expired)
				wd_cause_r <= 1'b1;
			else if (al_r == fbsup_pkg::AL_OP && pd_rx_strobe)
				wd_cause_r <= 1'b0;
		end
	end

	// Any commanded change while running is illegal; remember where we were
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ill_cause_r <= 1'b0;
			hold_state_r <= fbsup_pkg::AL_INIT;
		end
		else if (ce)
		begin
			if (al_req_valid && motor_run_s && al_req_state != al_code(al_r))
			begin
				ill_cause_r <= 1'b1;
				if (!ill_cause_r)
					hold_state_r <= al_r;
			end
			else if (ill_cause_r && al_r == hold_state_r)
				ill_cause_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Arming and reset sources
	// ----------------------------------------------------------------
	logic pd_seen_r; // Nonzero process data seen once
	logic button_d_r; // Previous button level
	logic io_reset_d_r; // Previous terminal level
	logic reset_req; // Any reset request this cycle
	logic armed; // Fault may be raised

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pd_seen_r <= 1'b0;
			button_d_r <= 1'b0;
			io_reset_d_r <= 1'b0;
		end
		else if (ce)
		begin
			if (pd_rx_strobe && pd_nonzero)
				pd_seen_r <= 1'b1;
			button_d_r <= button_s;
			io_reset_d_r <= io_reset_s;
		end
	end

	assign armed = !arm_nonzero_r || pd_seen_r;
	// Rising edges on pins, fieldbus pulse, software write
	assign reset_req = (button_s && !button_d_r) || (io_reset_s && !io_reset_d_r) ||
		fb_fault_reset || sw_reset_r;

	// ----------------------------------------------------------------
	// Fault latch and detail code
	// ----------------------------------------------------------------
	// Raising wins over a reset in the same cycle
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fieldbus_timeout_fault <= 1'b0;
			fault_cause_detail_code <= `FBS_DETAIL_NONE;
		end
		else if (ce)
		begin
			// Expiry lags a cleared cause by a cycle, so the cause must still stand
			if (!fieldbus_timeout_fault && comm_expired && cause_any && place_fb_r && armed)
			begin
				fieldbus_timeout_fault <= 1'b1;
				if (link_cause)
					fault_cause_detail_code <= `FBS_DETAIL_LINK;
				else if (wd_cause_r)
					fault_cause_detail_code <= `FBS_DETAIL_WD;
				else
					fault_cause_detail_code <= `FBS_DETAIL_ILLEGAL;
			end
			else if (fieldbus_timeout_fault && reset_req && !cause_any)
				fieldbus_timeout_fault <= 1'b0;
		end
	end

	// Status word for software
	assign status_w = {16'h0000, refused_r, armed, control_from_process_data, ill_cause_r, wd_cause_r,
		link_cause, fault_cause_detail_code, fieldbus_timeout_fault, al_code(al_r)};

endmodule : fieldbus_fault_supervisor

`default_nettype wire
